// >>> hw/rhpm_master.sv
// Half-duplex RS-485 packet master: idle-gap framing and driver gating
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
module rhpm_master #(
  parameter int PKT_MAX = rhpm_pkg::RHPM_PKT_MAX
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [7:0] net_tx_data,
  input wire logic net_tx_valid,
  input wire logic net_tx_last,
  output logic net_tx_ready,
  output logic [7:0] net_rx_data,
  output logic net_rx_valid,
  output logic net_rx_perr,
  output logic net_rx_end,
  input wire logic rs485_rxd,
  output logic rs485_txd,
  output logic rs485_de
);
  import rhpm_pkg::*;

  localparam int CW = $clog2(PKT_MAX + 1);

  typedef enum logic [1:0] {M_LISTEN, M_SEND, M_DRAIN} rhpm_mode_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [15:0] baud;
    logic [1:0] par;
    logic [7:0] rxi;
    logic [7:0] txi;
    logic [7:0] txen;
    logic [31:0] rdata;
    logic [PKT_MAX-1:0][7:0] mem;
    logic [CW-1:0] wcnt;
    logic [CW-1:0] rptr;
    logic full;
    logic ready;
    rhpm_mode_t mode;
    logic de;
    logic tx_valid;
    logic [19:0] icyc;
    logic [7:0] ichars;
    logic rx_pend;
    logic rxv;
    logic [7:0] rxd;
    logic perr;
    logic rxend;
  } rhpm_state_t;

  rhpm_state_t st;
  rhpm_state_t next_st;

  logic tx_ready;
  logic tx_busy;
  logic rx_busy;
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_perr;
  logic rx_act;
  logic line_act;
  logic tx_take;
  logic [19:0] char_cyc;
  logic [7:0] wait_chars;

  // Serial engine; the receiver is blind while we drive the line
  rhpm_serdes u_serdes (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .baud(st.baud),
    .par(st.par),
    .tx_valid(st.tx_valid),
    .tx_data(st.mem[st.rptr]),
    .tx_ready(tx_ready),
    .tx_busy(tx_busy),
    .txd(rs485_txd),
    .rxd(st.sync2),
    .rx_en(!st.de),
    .rx_busy(rx_busy),
    .rx_done(rx_done),
    .rx_data(rx_data),
    .rx_perr(rx_perr)
  );

  // Line activity and timing figures derived from the configuration
  assign rx_act = !st.sync2 || rx_busy;
  assign line_act = st.de || rx_act;
  assign tx_take = st.tx_valid && tx_ready;
  assign char_cyc = 20'(st.baud) * RHPM_FRAME_BITS;
  assign wait_chars = (st.txi > st.txen) ? st.txi : st.txen;

  // Next-state logic for the whole port
  always_comb begin
    next_st = st;
    next_st.sync1 = rs485_rxd;
    next_st.sync2 = st.sync1;
    next_st.rxv = 1'b0;
    next_st.rxend = 1'b0;
    next_st.rdata = 32'h00000000;

    // Register writes; unmapped offsets are ignored
    if (reg_wr) begin
      case (reg_addr)
        RHPM_ADDR_BAUD: next_st.baud = reg_wdata[15:0];
        RHPM_ADDR_CFG: next_st.par = reg_wdata[1:0];
        RHPM_ADDR_RXIDLE: next_st.rxi = reg_wdata[7:0];
        RHPM_ADDR_TXIDLE: next_st.txi = reg_wdata[7:0];
        RHPM_ADDR_TXEN: next_st.txen = reg_wdata[7:0];
        default: next_st.baud = st.baud;
      endcase
    end

    // Register reads answer one cycle later; unmapped reads return zero
    if (reg_rd) begin
      case (reg_addr)
        RHPM_ADDR_BAUD: next_st.rdata[15:0] = st.baud;
        RHPM_ADDR_CFG: next_st.rdata[1:0] = st.par;
        RHPM_ADDR_RXIDLE: next_st.rdata[7:0] = st.rxi;
        RHPM_ADDR_TXIDLE: next_st.rdata[7:0] = st.txi;
        RHPM_ADDR_TXEN: next_st.rdata[7:0] = st.txen;
        RHPM_ADDR_STAT: begin
          next_st.rdata[CW-1:0] = st.wcnt;
          next_st.rdata[RHPM_STAT_IDLE +: 8] = st.ichars;
          next_st.rdata[RHPM_STAT_RXACT] = rx_act;
          next_st.rdata[RHPM_STAT_DE] = st.de;
          next_st.rdata[RHPM_STAT_FULL] = st.full;
          next_st.rdata[RHPM_STAT_PERR] = st.perr;
        end
        default: next_st.rdata = 32'h00000000;
      endcase
    end

    // Idle timer in whole characters; any activity restarts it
    if (line_act) begin
      next_st.icyc = 20'h00000;
      next_st.ichars = 8'h00;
    end else if (st.icyc >= char_cyc - 20'h00001) begin
      next_st.icyc = 20'h00000;
      if (st.ichars != 8'hff) begin
        next_st.ichars = st.ichars + 8'h01;
      end
    end else begin
      next_st.icyc = st.icyc + 20'h00001;
    end

    // Received characters stream straight to the network side
    if (rx_done && !st.de) begin
      next_st.rxv = 1'b1;
      next_st.rxd = rx_data;
      next_st.perr = rx_perr;
      next_st.rx_pend = 1'b1;
    end else if (st.rx_pend && !line_act && st.ichars >= st.rxi) begin
      next_st.rxend = 1'b1;
      next_st.rx_pend = 1'b0;
    end

    // Fill the packet buffer; an overlong packet is closed at the limit
    if (st.ready && net_tx_valid) begin
      next_st.mem[st.wcnt] = net_tx_data;
      next_st.wcnt = st.wcnt + CW'(1);
      if (net_tx_last || st.wcnt == CW'(PKT_MAX - 1)) begin
        next_st.full = 1'b1;
      end
    end

    // Driver control: listen, burst out, then wait for the stop bit
    unique case (st.mode)
      M_LISTEN: begin
        // Only a complete packet after the hold-off may turn the driver on
        if (st.full && !rx_act && st.ichars >= wait_chars) begin
          next_st.de = 1'b1;
          next_st.tx_valid = 1'b1;
          next_st.rptr = '0;
          next_st.mode = M_SEND;
        end
      end
      M_SEND: begin
        // Valid stays high so each frame follows the last stop bit directly
        if (tx_take) begin
          if (st.rptr == st.wcnt - CW'(1)) begin
            next_st.tx_valid = 1'b0;
            next_st.mode = M_DRAIN;
          end else begin
            next_st.rptr = st.rptr + CW'(1);
          end
        end
      end
      M_DRAIN: begin
        // Release the line as soon as the final stop bit is out
        if (!tx_busy) begin
          next_st.de = 1'b0;
          next_st.full = 1'b0;
          next_st.wcnt = '0;
          next_st.mode = M_LISTEN;
        end
      end
      default: begin
        // Unused code: fall back to listening with the driver off
        next_st.mode = M_LISTEN;
        next_st.de = 1'b0;
      end
    endcase

    // Registered ready: one packet is queued at a time
    next_st.ready = !next_st.full;
  end

  // The only state register of the port
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.sync1 <= 1'b1;
      st.sync2 <= 1'b1;
      st.baud <= RHPM_BAUD_RST;
      st.par <= RHPM_PAR_RST;
      st.rxi <= RHPM_RXIDLE_RST;
      st.txi <= RHPM_TXIDLE_RST;
      st.txen <= RHPM_TXEN_RST;
      st.ready <= 1'b1;
      st.mode <= M_LISTEN;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign net_tx_ready = st.ready;
  assign net_rx_data = st.rxd;
  assign net_rx_valid = st.rxv;
  assign net_rx_perr = st.perr;
  assign net_rx_end = st.rxend;
  assign rs485_de = st.de;

  // Driver only rises after the larger idle setting has elapsed
  AST_TX_WAIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(st.de) |-> $past(st.ichars) >= $past(wait_chars))
    else $error("driver enabled before idle wait elapsed");

  // Driver only rises with a complete packet queued
  AST_FULL_FIRST: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(st.de) |-> $past(st.full) && st.tx_valid)
    else $error("transmit started without a full packet");

  // Ready is low whenever a packet is queued
  AST_READY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.full |-> !st.ready)
    else $error("network ready while packet queued");

  // A reception in progress keeps the driver off
  AST_RX_BLOCK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!st.de && rx_busy) |=> !st.de)
    else $error("driver enabled during reception");

  // Burst: while sending, a byte is always offered to the serialiser
  AST_BURST: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.mode == M_SEND |-> st.tx_valid && st.de)
    else $error("gap inside transmit burst");

  // Driver drops once the final stop bit has left, and the timer restarts
  AST_DE_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(st.de) |-> $past(st.mode) == M_DRAIN && !$past(tx_busy) && st.ichars == 8'h00)
    else $error("driver released at wrong time");

  // Packet end only after the receive idle count
  AST_RX_END: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.rxend |-> $past(st.ichars) >= $past(st.rxi) && !st.rx_pend)
    else $error("receive packet ended early");

  // A character time advances only after eleven bit periods
  AST_CHAR_TIME: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st.ichars != $past(st.ichars) && st.ichars != 8'h00) |->
      $past(st.icyc) >= $past(char_cyc) - 20'h00001)
    else $error("character time counted early");

  // Own transmissions never reach the network side
  AST_NO_ECHO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.de |=> !st.rxv)
    else $error("own transmission forwarded");

  // Buffer never exceeds the packet limit
  AST_BUF_LIMIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.wcnt <= CW'(PKT_MAX))
    else $error("packet buffer overrun");

endmodule // rhpm_master

// >>> hw/rhpm_serdes.sv
// Character serialiser and deserialiser, 11-bit frame with parity
`timescale 1ns/100ps
module rhpm_serdes (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] baud,
  input wire logic [1:0] par,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic tx_busy,
  output logic txd,
  input wire logic rxd,
  input wire logic rx_en,
  output logic rx_busy,
  output logic rx_done,
  output logic [7:0] rx_data,
  output logic rx_perr
);
  import rhpm_pkg::*;

  typedef struct packed {
    logic [15:0] tcnt;
    logic [3:0] tbit;
    logic [9:0] tsh;
    logic tbusy;
    logic txd;
    logic [15:0] rcnt;
    logic [3:0] rbit;
    logic [8:0] rsh;
    logic rbusy;
    logic rdone;
    logic [7:0] rdat;
    logic rperr;
  } rhpm_ser_t;

  rhpm_ser_t st;
  rhpm_ser_t next_st;
  logic tx_last;
  logic [15:0] rx_target;

  // Ready in the final stop-bit cycle so the next frame follows with no gap
  assign tx_last = st.tbusy && st.tcnt == baud - 16'h0001 && st.tbit == RHPM_LAST_BIT;
  assign tx_ready = !st.tbusy || tx_last;
  assign rx_target = (st.rbit == 4'h0) ? {1'b0, baud[15:1]} : baud - 16'h0001;

  // Bit timing for both directions
  always_comb begin
    next_st = st;
    next_st.rdone = 1'b0;
    if (tx_valid && tx_ready) begin
      next_st.tbusy = 1'b1;
      next_st.tcnt = 16'h0000;
      next_st.tbit = 4'h0;
      next_st.txd = 1'b0;
      next_st.tsh = {1'b1, rhpm_par(par, tx_data), tx_data};
    end else if (st.tbusy) begin
      if (st.tcnt == baud - 16'h0001) begin
        next_st.tcnt = 16'h0000;
        next_st.tbit = st.tbit + 4'h1;
        if (st.tbit == RHPM_LAST_BIT) begin
          next_st.tbusy = 1'b0;
          next_st.txd = 1'b1;
        end else begin
          next_st.txd = st.tsh[0];
          next_st.tsh = {1'b1, st.tsh[9:1]};
        end
      end else begin
        next_st.tcnt = st.tcnt + 16'h0001;
      end
    end
    // Receiver samples mid-bit; a start bit that does not hold is dropped
    if (!st.rbusy) begin
      if (rx_en && !rxd) begin
        next_st.rbusy = 1'b1;
        next_st.rcnt = 16'h0000;
        next_st.rbit = 4'h0;
      end
    end else if (st.rcnt == rx_target) begin
      next_st.rcnt = 16'h0000;
      next_st.rbit = st.rbit + 4'h1;
      if (st.rbit == 4'h0 && rxd) begin
        next_st.rbusy = 1'b0;
      end else if (st.rbit == RHPM_LAST_BIT) begin
        next_st.rbusy = 1'b0;
        next_st.rdone = 1'b1;
        next_st.rdat = st.rsh[7:0];
        next_st.rperr = st.rsh[8] != rhpm_par(par, st.rsh[7:0]);
      end else if (st.rbit != 4'h0) begin
        next_st.rsh = {rxd, st.rsh[8:1]};
      end
    end else begin
      next_st.rcnt = st.rcnt + 16'h0001;
    end
  end

  // State register; the line idles high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.txd <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign tx_busy = st.tbusy;
  assign txd = st.txd;
  assign rx_busy = st.rbusy;
  assign rx_done = st.rdone;
  assign rx_data = st.rdat;
  assign rx_perr = st.rperr;

endmodule // rhpm_serdes

// >>> include/rhpm_pkg.sv
// Shared constants and parity helper for the RS-485 packet master port
package rhpm_pkg;

  // Register byte offsets, one 32-bit word each
  localparam logic [7:0] RHPM_ADDR_BAUD = 8'h00;
  localparam logic [7:0] RHPM_ADDR_CFG = 8'h04;
  localparam logic [7:0] RHPM_ADDR_RXIDLE = 8'h08;
  localparam logic [7:0] RHPM_ADDR_TXIDLE = 8'h0c;
  localparam logic [7:0] RHPM_ADDR_TXEN = 8'h10;
  localparam logic [7:0] RHPM_ADDR_STAT = 8'h14;

  // Parity selections held in the low bits of the config word
  localparam logic [1:0] RHPM_PAR_EVEN = 2'h0;
  localparam logic [1:0] RHPM_PAR_ODD = 2'h1;
  localparam logic [1:0] RHPM_PAR_MARK = 2'h2;

  // Values after reset: 87 clocks per bit is about 115200 baud at 10 MHz
  localparam logic [15:0] RHPM_BAUD_RST = 16'h0057;
  localparam logic [1:0] RHPM_PAR_RST = 2'h2;
  localparam logic [7:0] RHPM_RXIDLE_RST = 8'h04;
  localparam logic [7:0] RHPM_TXIDLE_RST = 8'h04;
  localparam logic [7:0] RHPM_TXEN_RST = 8'h14;

  // Frame geometry: start, eight data, parity, stop
  localparam logic [19:0] RHPM_FRAME_BITS = 20'h0000b;
  localparam logic [3:0] RHPM_LAST_BIT = 4'ha;
  localparam int RHPM_PKT_MAX = 1020;

  // Status word field positions; the byte count sits from bit 0 upward
  localparam int RHPM_STAT_IDLE = 16;
  localparam int RHPM_STAT_RXACT = 24;
  localparam int RHPM_STAT_DE = 25;
  localparam int RHPM_STAT_FULL = 26;
  localparam int RHPM_STAT_PERR = 27;

  // Parity bit for a byte; the unused code falls back to mark
  function automatic logic rhpm_par(input logic [1:0] sel, input logic [7:0] d);
    if (sel == RHPM_PAR_EVEN) begin
      return ^d;
    end else if (sel == RHPM_PAR_ODD) begin
      return ~^d;
    end
    return 1'b1;
  endfunction

endpackage

// >>> tb/rhpm_slave_model.sv
// Slave node on the RS-485 cable: frame decoder and commanded replies
`timescale 1ns/100ps
module rhpm_slave_model #(
  parameter int BIT_CLKS = 4
) (
  input wire logic sys_clk,
  input wire logic line,
  input wire logic [1:0] par,
  input wire logic go,
  input wire logic bad_last,
  input wire logic [7:0] delay_chars,
  input wire logic [31:0] reply_bytes,
  output logic drv,
  output logic drv_val,
  output logic cap_stb,
  output logic [7:0] cap_byte,
  output logic cap_par_ok,
  output logic [15:0] cap_gap
);
  int cyc = 0;
  int last_st = 0;
  logic [10:0] bits;
  logic [10:0] fr;

  // Parity as every node must compute it
  function automatic logic par_bit(input logic [1:0] sel, input logic [7:0] d);
    case (sel)
      2'h0: return ^d;
      2'h1: return ~^d;
      default: return 1'b1;
    endcase
  endfunction

  initial begin
    drv = 1'b0;
    drv_val = 1'b1;
    cap_stb = 1'b0;
  end

  always @(posedge sys_clk) cyc <= cyc + 1;

  // Decode master frames mid-bit, LSB first; gap is start to start
  always begin
    @(negedge line);
    if (!drv) begin
      @(posedge sys_clk);
      cap_gap <= 16'(cyc - last_st);
      last_st = cyc;
      repeat (BIT_CLKS / 2 - 1) @(posedge sys_clk);
      for (int i = 0; i < 11; i++) begin
        bits[i] = line;
        if (i < 10) repeat (BIT_CLKS) @(posedge sys_clk);
      end
      cap_byte <= bits[8:1];
      cap_par_ok <= !bits[0] && bits[10] && bits[9] == par_bit(par, bits[8:1]);
      cap_stb <= 1'b1;
      @(posedge sys_clk);
      cap_stb <= 1'b0;
    end
  end

  // Talk only when go is raised, after a full idle lead-in; no gaps inside
  always begin
    do @(posedge sys_clk); while (go !== 1'b1);
    repeat (11 * BIT_CLKS * int'(delay_chars)) @(posedge sys_clk);
    drv <= 1'b1;
    for (int b = 0; b < 4; b++) begin
      fr = {1'b1, par_bit(par, reply_bytes[8*b +: 8]) ^ (bad_last && b == 3),
            reply_bytes[8*b +: 8], 1'b0};
      for (int k = 0; k < 11; k++) begin
        drv_val <= fr[k];
        repeat (BIT_CLKS) @(posedge sys_clk);
      end
    end
    drv <= 1'b0;
  end
endmodule // rhpm_slave_model

// >>> tb/tb.sv
// Testbench for the RS-485 packet master with a slave model on the line
`timescale 1ns/100ps
module tb;
  import rhpm_pkg::*;
  localparam int BIT = 4;
  localparam int CH = 11 * BIT;
  localparam int PMAX = 8;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] net_tx_data = 8'h00;
  logic net_tx_valid = 1'b0;
  logic net_tx_last = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] net_rx_data, cap_byte;
  logic net_tx_ready, net_rx_valid, net_rx_perr, net_rx_end, rs485_txd, rs485_de;
  logic p_drv, p_val, cap_stb, cap_ok;
  logic [15:0] cap_gap;
  logic [1:0] p_par = 2'h0;
  logic p_go = 1'b0;
  logic p_bad = 1'b0;
  logic [7:0] p_dly = 8'h04;
  logic [31:0] p_bytes = 32'h0;
  logic [31:0] exp_reg [$];
  logic [9:0] exp_net [$];
  logic [7:0] exp_line [$];
  int err_total = 0;
  int tests_run = 0;
  int seed = 32'hfd9c;
  int need, idle_cyc, st_cyc, rx_cyc;
  int txi [3] = '{6, 2, 4};
  int txe [3] = '{3, 5, 4};
  logic prompt = 1'b0;
  logic rd_pend = 1'b0;
  logic de_d = 1'b0;
  logic line_d = 1'b1;
  // Fail-safe bias: an undriven cable reads idle high
  wire line = rs485_de ? rs485_txd : (p_drv ? p_val : 1'b1);

  rhpm_master #(.PKT_MAX(PMAX)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .net_tx_data(net_tx_data), .net_tx_valid(net_tx_valid), .net_tx_last(net_tx_last),
    .net_tx_ready(net_tx_ready), .net_rx_data(net_rx_data), .net_rx_valid(net_rx_valid),
    .net_rx_perr(net_rx_perr), .net_rx_end(net_rx_end), .rs485_rxd(line),
    .rs485_txd(rs485_txd), .rs485_de(rs485_de));
  rhpm_slave_model #(.BIT_CLKS(BIT)) slave (.sys_clk(sys_clk), .line(line), .par(p_par),
    .go(p_go), .bad_last(p_bad), .delay_chars(p_dly), .reply_bytes(p_bytes), .drv(p_drv),
    .drv_val(p_val), .cap_stb(cap_stb), .cap_byte(cap_byte), .cap_par_ok(cap_ok),
    .cap_gap(cap_gap));

  always #50 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_reg.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  // Offer n random bytes; each is noted once ready shows it will be taken
  task automatic send_pkt(input int n, input logic close);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      @(posedge sys_clk);
      net_tx_valid <= 1'b1;
      net_tx_data <= b;
      net_tx_last <= close && i == n - 1;
      @(negedge sys_clk);
      while (net_tx_ready !== 1'b1) @(negedge sys_clk);
      exp_line.push_back(b);
    end
    @(posedge sys_clk);
    net_tx_valid <= 1'b0;
    net_tx_last <= 1'b0;
  endtask

  task automatic wait_de(input logic v);
    int k;
    k = 0;
    while (rs485_de !== v && k < 3000) begin
      @(negedge sys_clk);
      k++;
    end
    check(32'(k < 3000), 32'h1);
  endtask

  // Monitor: settled outputs at the falling edge, compared with oldest notes
  always @(negedge sys_clk) begin
    if (rd_pend) check(reg_rdata, exp_reg.pop_front());
    rd_pend = reg_rd;
    rx_cyc++;
    if (net_rx_valid === 1'b1) begin
      check(32'({net_rx_perr, net_rx_data}), 32'(exp_net.pop_front()));
      rx_cyc = 0;
    end
    if (net_rx_end === 1'b1) begin
      check(32'(exp_net.pop_front()), 32'h200);
      check(32'(rx_cyc >= 4 * CH - BIT && rx_cyc <= 5 * CH), 32'h1);
    end
    if (cap_stb === 1'b1) begin
      check(32'(cap_byte), 32'(exp_line.pop_front()));
      check(32'(cap_ok), 32'h1);
      if (cap_gap < 2 * CH) check(32'(cap_gap), 32'(CH));
    end
    idle_cyc = (line === 1'b0) ? 0 : idle_cyc + 1;
    // Only a fall at least ten bit periods after the last start is a start bit, not a data edge
    st_cyc = (rs485_de === 1'b1 && line_d === 1'b1 && line === 1'b0 && st_cyc >= CH - BIT) ?
      0 : st_cyc + 1;
    if (rs485_de === 1'b1 && de_d === 1'b0) begin
      check(32'(idle_cyc >= need * CH), 32'h1);
      if (prompt) check(32'(idle_cyc <= (need + 2) * CH), 32'h1);
    end
    if (rs485_de === 1'b0 && de_d === 1'b1) check(32'(st_cyc >= CH && st_cyc <= CH + 3), 1);
    de_d = rs485_de;
    line_d = line;
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Reset values; the unmapped write must leave nothing behind
    reg_write(8'h18, 32'hffffffff);
    reg_read(RHPM_ADDR_BAUD, 32'(RHPM_BAUD_RST));
    reg_read(RHPM_ADDR_CFG, 32'h2);
    reg_read(RHPM_ADDR_RXIDLE, 32'h4);
    reg_read(RHPM_ADDR_TXIDLE, 32'h4);
    reg_read(RHPM_ADDR_TXEN, 32'h14);
    reg_read(8'h18, 32'h0);
    // Each parity mode, with either idle setting the larger one
    for (int p = 0; p < 3; p++) begin
      p_par <= 2'(p);
      need = txi[p] > txe[p] ? txi[p] : txe[p];
      reg_write(RHPM_ADDR_BAUD, 32'(BIT));
      reg_write(RHPM_ADDR_CFG, 32'(p));
      reg_write(RHPM_ADDR_TXIDLE, 32'(txi[p]));
      reg_write(RHPM_ADDR_TXEN, 32'(txe[p]));
      send_pkt(2, 1'b0);
      repeat ((need + 2) * CH) @(negedge sys_clk);
      check(32'(rs485_de), 32'h0);
      send_pkt(2, 1'b1);
      wait_de(1'b1);
      wait_de(1'b0);
      // Slow slave reply, last byte spoilt once; a packet queued meanwhile waits
      p_bytes <= $random(seed);
      p_bad <= p == 2;
      p_dly <= 8'(4 + 2 * p);
      @(posedge sys_clk);
      p_go <= 1'b1;
      @(posedge sys_clk);
      p_go <= 1'b0;
      for (int i = 0; i < 4; i++) exp_net.push_back({1'b0, p == 2 && i == 3, p_bytes[8*i +: 8]});
      exp_net.push_back(10'h200);
      repeat ((5 + 2 * p) * CH) @(negedge sys_clk);
      prompt = 1'b1;
      send_pkt(2, 1'b1);
      check(32'(rs485_de), 32'h0);
      wait_de(1'b1);
      wait_de(1'b0);
      prompt = 1'b0;
    end
    // Code 3 parity behaves as mark, which the slave still expects
    reg_write(RHPM_ADDR_CFG, 32'h3);
    reg_read(RHPM_ADDR_CFG, 32'h3);
    // No closing marker: the buffer limit closes the packet
    send_pkt(PMAX, 1'b0);
    @(negedge sys_clk);
    check(32'(net_tx_ready), 32'h0);
    wait_de(1'b1);
    wait_de(1'b0);
    repeat (4) @(negedge sys_clk);
    check(32'(exp_line.size() + exp_net.size() + exp_reg.size()), 32'h0);
    report_and_stop();
  end

  // Watchdog: the sequence needs well under 10000 cycles
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    report_and_stop();
  end
endmodule // tb
